/* design/quad_reload_timer_unit.sv */
/*
  Four 8-bit reload timers with prescalers behind an APB slave: timers 1
  and 2 on a shared prescaler, timers X and Y with four modes each, two
  counter pins and a level interrupt. Assumes pclk is the main oscillation
  and that sub_osc_input and the counter pins are asynchronous.
*/
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "qrt_regs.svh"

// Notes on behaviour
// - Each stage divides its source by latch plus one.
// - Count down, reload on tick at zero, continue.
// - Every timer underflow sets that timer's request bit.
// - Timers 1 and 2 prescaler counts main divided sixteen.
// - Timers X and Y each pick one of four modes.
// - Pulse mode toggles counter pin at each zero.
// - Pulse output starts high for edge bit zero.
// - Event mode counts rising or falling pin edges.
// - Width mode counts only while pin at active level.
// - Stop bit halts timer X or Y, value held.
// - Timer Y source is main sixteenth or sub oscillator.
module quad_reload_timer_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire qrt_pkg::apb_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  input wire logic counter_pin_a_in,
  output logic counter_pin_a_out,
  output logic counter_pin_a_oe,
  input wire logic counter_pin_b_in,
  output logic counter_pin_b_out,
  output logic counter_pin_b_oe,
  input wire logic sub_osc_input
);
  import qrt_pkg::*;

  localparam int NC = 7;
  localparam int PRE12 = 0;
  localparam int TMR1 = 1;
  localparam int TMR2 = 2;
  localparam int PREX = 3;
  localparam int TMRX = 4;
  localparam int PREY = 5;
  localparam int TMRY = 6;

  cnt_if #(.W(8)) cif [NC] ();

  logic [3:0] div_q;
  logic pre16;
  byte_t mode_q;
  byte_t port_control_two_q;
  logic [3:0] stat_q;
  logic [3:0] ien_q;
  logic [3:0] stat_set;
  logic [3:0] stat_clr;
  logic [31:0] prdata_q;
  logic out_a_q;
  logic out_b_q;

  tmr_mode_t mode_x;
  tmr_mode_t mode_y;
  logic edge_x;
  logic edge_y;
  logic stop_x;
  logic stop_y;
  logic ysrc_sub;

  logic lvl_a;
  logic rise_a;
  logic fall_a;
  logic lvl_b;
  logic rise_b;
  logic fall_b;
  logic sub_rise;

  logic src_x;
  logic src_y;
  logic y_base;

  logic setup_ph;
  logic wr_en;
  logic mode_wr;
  logic map_hit;
  logic cnt_hit;
  logic [2:0] cnt_idx;
  byte_t cnt_rd [NC];
  byte_t rd_byte;

  pin_sync u_sync_a (
    .pclk(pclk),
    .presetn(presetn),
    .din(counter_pin_a_in),
    .level(lvl_a),
    .rise(rise_a),
    .fall(fall_a)
  );

  pin_sync u_sync_b (
    .pclk(pclk),
    .presetn(presetn),
    .din(counter_pin_b_in),
    .level(lvl_b),
    .rise(rise_b),
    .fall(fall_b)
  );

  pin_sync u_sync_sub (
    .pclk(pclk),
    .presetn(presetn),
    .din(sub_osc_input),
    .level(),
    .rise(sub_rise),
    .fall()
  );

  // Main oscillation divided by sixteen as a one-cycle enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign pre16 = (div_q == 4'(`QRT_MAIN_DIV - 5'h01));

  // Mode fields and control bits.
  assign mode_x = tmr_mode_t'(mode_q[`QRT_MODE_X_LSB +: 2]);
  assign mode_y = tmr_mode_t'(mode_q[`QRT_MODE_Y_LSB +: 2]);
  assign edge_x = mode_q[`QRT_EDGE_X_BIT];
  assign edge_y = mode_q[`QRT_EDGE_Y_BIT];
  assign stop_x = mode_q[`QRT_STOP_X_BIT];
  assign stop_y = mode_q[`QRT_STOP_Y_BIT];
  assign ysrc_sub = port_control_two_q[`QRT_YSRC_BIT];

  // Count sources of the X and Y chains.
  assign y_base = ysrc_sub ? sub_rise : pre16;
  assign src_x = (mode_x == mode_event) ? (edge_x ? fall_a : rise_a) :
                 (mode_x == mode_width) ? (pre16 & (lvl_a ^ edge_x)) :
                 pre16;
  assign src_y = (mode_y == mode_event) ? (edge_y ? fall_b : rise_b) :
                 (mode_y == mode_width) ? (pre16 & (lvl_b ^ edge_y)) :
                 y_base;

  // Chain wiring: each timer counts the underflows of its prescaler.
  assign cif[PRE12].tick = pre16;
  assign cif[TMR1].tick = cif[PRE12].uf;
  assign cif[TMR2].tick = cif[PRE12].uf;
  assign cif[PREX].tick = src_x & ~stop_x;
  assign cif[TMRX].tick = cif[PREX].uf;
  assign cif[PREY].tick = src_y & ~stop_y;
  assign cif[TMRY].tick = cif[PREY].uf;

  // APB decode.
  assign setup_ph = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign mode_wr = wr_en && (paddr == `QRT_OFF_MODE);
  assign map_hit = (paddr[1:0] == 2'h0) && (paddr <= `QRT_OFF_IEN);
  assign cnt_idx = paddr[4:2];
  assign cnt_hit = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0) &&
                   (cnt_idx < `QRT_NUM_CNT);

  for (genvar i = 0; i < NC; i++) begin : g_cnt
    assign cif[i].load = wr_en && (paddr == 8'(i * 4));
    assign cif[i].load_val = pwdata[7:0];
    assign cnt_rd[i] = cif[i].count;
    reload_counter #(.W(8), .RST(`QRT_CNT_RST)) u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .bus(cif[i])
    );
  end

  assign rd_byte = cnt_hit ? cnt_rd[cnt_idx] :
                   (paddr == `QRT_OFF_MODE) ? mode_q :
                   (paddr == `QRT_OFF_PORT_CONTROL_TWO) ? port_control_two_q :
                   (paddr == `QRT_OFF_STAT) ? {4'h0, stat_q} :
                   (paddr == `QRT_OFF_IEN) ? {4'h0, ien_q} :
                   8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = psel & penable & ~map_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `QRT_MODE_RST;
      port_control_two_q <= `QRT_PORT_CONTROL_TWO_RST;
      ien_q <= 4'h0;
    end else if (wr_en) begin
      if (paddr == `QRT_OFF_MODE) begin
        mode_q <= pwdata[7:0];
      end
      if (paddr == `QRT_OFF_PORT_CONTROL_TWO) begin
        port_control_two_q <= pwdata[7:0];
      end
      if (paddr == `QRT_OFF_IEN) begin
        ien_q <= pwdata[3:0];
      end
    end
  end

  // Sticky request bits; a set in the clearing cycle wins.
  assign stat_set[`QRT_STAT_X_BIT] = cif[TMRX].uf;
  assign stat_set[`QRT_STAT_Y_BIT] = cif[TMRY].uf;
  assign stat_set[`QRT_STAT_1_BIT] = cif[TMR1].uf;
  assign stat_set[`QRT_STAT_2_BIT] = cif[TMR2].uf;
  assign stat_clr = (wr_en && paddr == `QRT_OFF_CLR) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | stat_set;
    end
  end

  assign irq = |(stat_q & ien_q);

  // Pulse outputs: preset from the edge bit on a mode write, toggled at each zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_q <= 1'b1;
      out_b_q <= 1'b1;
    end else if (mode_wr) begin
      out_a_q <= ~pwdata[`QRT_EDGE_X_BIT];
      out_b_q <= ~pwdata[`QRT_EDGE_Y_BIT];
    end else begin
      if (mode_x != mode_pulse) begin
        out_a_q <= ~edge_x;
      end else if (cif[TMRX].uf) begin
        out_a_q <= ~out_a_q;
      end
      if (mode_y != mode_pulse) begin
        out_b_q <= ~edge_y;
      end else if (cif[TMRY].uf) begin
        out_b_q <= ~out_b_q;
      end
    end
  end

  // The pin is driven only in pulse mode; the unit drives the output enable from the mode field.
  assign counter_pin_a_out = out_a_q;
  assign counter_pin_a_oe = (mode_x == mode_pulse);
  assign counter_pin_b_out = out_b_q;
  assign counter_pin_b_oe = (mode_y == mode_pulse);

  div_spacing_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pre16 |=> !pre16 [*8] ##8 pre16)
    else $error("Main divide-by-sixteen enable has the wrong spacing.");

  irq_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cif[TMRX].uf |=> stat_q[`QRT_STAT_X_BIT] && (irq || !ien_q[`QRT_STAT_X_BIT]))
    else $error("Timer X underflow did not set its request bit.");

  t12_share_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cif[TMR1].tick |-> pre16 && cif[PRE12].count == 8'h00)
    else $error("Timers 1 and 2 counted without a prescaler underflow.");

  stop_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (stop_x && !cif[PREX].load && !cif[TMRX].load) |=>
      $stable(cif[TMRX].count) && $stable(cif[PREX].count))
    else $error("Timer X counted while stopped.");

  pulse_toggle_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_x == mode_pulse && cif[TMRX].uf) ##1 (mode_x == mode_pulse) |->
      counter_pin_a_out != $past(counter_pin_a_out))
    else $error("Pulse output did not invert at timer zero.");

  pulse_start_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_y != mode_pulse) ##1 (mode_y == mode_pulse) |->
      counter_pin_b_out == !edge_y)
    else $error("Pulse output started at the wrong level.");

  event_edge_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_x == mode_event && !stop_x && !edge_x && rise_a && !cif[PREX].load &&
      cif[PREX].count != 8'h00) |=> cif[PREX].count == $past(cif[PREX].count) - 8'h01)
    else $error("Event mode missed a rising pin edge.");

  width_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_y == mode_width && (lvl_b == edge_y) && !cif[PREY].load) |=>
      $stable(cif[PREY].count))
    else $error("Width mode counted while pin was inactive.");

  ysrc_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_y == mode_timer && ysrc_sub && !sub_rise && !cif[PREY].load) |=>
      $stable(cif[PREY].count))
    else $error("Timer Y counted the main clock with sub source selected.");

  mode_indep_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_x == mode_event && mode_y == mode_timer && !stop_y && pre16 && !ysrc_sub &&
      !cif[PREY].load) |-> cif[PREY].tick)
    else $error("Timer Y source depends on timer X mode.");
endmodule

/* design/qrt_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  quad reload timer unit. Assumes APB byte addresses with one 32-bit word
  per register, of which only the low eight bits carry data.
*/
`ifndef QRT_REGS_SVH
`define QRT_REGS_SVH

`define QRT_OFF_PRE12    8'h00
`define QRT_OFF_TMR1     8'h04
`define QRT_OFF_TMR2     8'h08
`define QRT_OFF_PREX     8'h0C
`define QRT_OFF_TMRX     8'h10
`define QRT_OFF_PREY     8'h14
`define QRT_OFF_TMRY     8'h18
`define QRT_OFF_MODE     8'h1C
`define QRT_OFF_PORT_CONTROL_TWO    8'h20
`define QRT_OFF_STAT     8'h24
`define QRT_OFF_CLR      8'h28
`define QRT_OFF_IEN      8'h2C
`define QRT_NUM_CNT      3'h7

`define QRT_MODE_X_LSB   0
`define QRT_EDGE_X_BIT   2
`define QRT_STOP_X_BIT   3
`define QRT_MODE_Y_LSB   4
`define QRT_EDGE_Y_BIT   6
`define QRT_STOP_Y_BIT   7
`define QRT_YSRC_BIT     5

`define QRT_STAT_X_BIT   0
`define QRT_STAT_Y_BIT   1
`define QRT_STAT_1_BIT   2
`define QRT_STAT_2_BIT   3

`define QRT_CNT_RST      8'hFF
`define QRT_MODE_RST     8'h00
`define QRT_PORT_CONTROL_TWO_RST    8'h00
`define QRT_MAIN_DIV     5'h10

`endif

/* design/qrt_pkg.sv */
/*
  Types shared by the quad reload timer unit. Assumes the constants of
  qrt_regs.svh are included where offsets are needed.
*/
package qrt_pkg;
  typedef logic [7:0] apb_addr_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    mode_timer,
    mode_pulse,
    mode_event,
    mode_width
  } tmr_mode_t;
endpackage

/* design/cnt_if.sv */
/*
  Carrier between the timer unit and one reload down counter. Assumes one
  clock shared by both ends.
*/
`timescale 1ns/100ps
interface cnt_if #(parameter int W = 8);
  logic tick;
  logic load;
  logic [W-1:0] load_val;
  logic [W-1:0] count;
  logic uf;
  modport ctl (output tick, output load, output load_val, input count, input uf);
  modport cnt (input tick, input load, input load_val, output count, output uf);
endinterface

/* design/pin_sync.sv */
/*
  Two-stage synchroniser for a pin, with level and edge outputs taken from
  the second stage onward. Assumes the pin is asynchronous to pclk.
*/
`timescale 1ns/100ps
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edges and level come only from the second stage and later.
  assign level = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

  edge_pair_a: assert property (
    @(posedge pclk) disable iff (!presetn) rise |=> level ##1 !rise)
    else $error("Rise edge not followed by a stable high level.");
endmodule

/* design/reload_counter.sv */
/*
  One down counter with a reload latch, used for timers and prescalers.
  Assumes tick is a one-cycle enable and load comes from a register write.
*/
`timescale 1ns/100ps
module reload_counter #(
  parameter int W = 8,
  parameter logic [7:0] RST = 8'hFF
) (
  input wire logic pclk,
  input wire logic presetn,
  cnt_if.cnt bus
);
  logic [W-1:0] latch_q;
  logic [W-1:0] cnt_q;
  logic at_zero;

  if (W < 1 || W > 8) begin : g_chk
    $error("reload_counter width must be 1 to 8.");
  end

  assign at_zero = (cnt_q == '0);
  // A tick at zero with no load in the same cycle is the underflow that reloads from the latch.
  assign bus.uf = bus.tick & at_zero & ~bus.load;
  assign bus.count = cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= RST[W-1:0];
      cnt_q <= RST[W-1:0];
    end else if (bus.load) begin
      latch_q <= bus.load_val;
      cnt_q <= bus.load_val;
    end else if (bus.tick) begin
      cnt_q <= at_zero ? latch_q : cnt_q - 1'b1;
    end
  end

  reload_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus.uf |=> cnt_q == $past(latch_q))
    else $error("Counter did not reload from its latch on underflow.");

  divide_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (bus.tick && !at_zero && !bus.load) |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("Counter did not step down by one on a tick.");
endmodule

/* test/qrt_pin_src.sv */
/*
  External sources on the counter pins and the sub oscillator input.
  Assumes the bench resolves each pin against the unit's own output enable.
*/
`timescale 1ns/100ps
module qrt_pin_src (
  input wire logic pclk,
  output logic pin_a,
  output logic pin_b,
  output logic sub_clk
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    sub_clk = 1'b0;
  end

  // Gives k whole pulses, each level held five cycles; the sub clock then stands still.
  task automatic burst(input int ch, input int k);
    repeat (2 * k) begin
      repeat (5) @(posedge pclk);
      case (ch)
        0: pin_a <= ~pin_a;
        1: pin_b <= ~pin_b;
        default: sub_clk <= ~sub_clk;
      endcase
    end
    repeat (5) @(posedge pclk);
  endtask

  task automatic set_a(input logic lv);
    @(posedge pclk);
    pin_a <= lv;
  endtask
endmodule

/* test/quad_reload_timer_unit_tb_top.sv */
/*
  Self-checking bench of the quad reload timer unit over APB.
  Assumes the register map and reset values of qrt_regs.svh.
*/
`timescale 1ns/100ps
`include "qrt_regs.svh"
module quad_reload_timer_unit_tb_top;
  import qrt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  apb_addr_t paddr;
  logic [31:0] pwdata, prdata;
  logic a_out, a_oe, b_out, b_oe, src_a, src_b, sub_clk;
  wire pin_a = a_oe ? a_out : src_a;
  wire pin_b = b_oe ? b_out : src_b;
  int error_cnt, n_tests, seed, cyc, t0, t1, n;
  logic [8:0] rq[$];
  logic [7:0] v;

  quad_reload_timer_unit i_quad_reload_timer_unit (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .counter_pin_a_in(pin_a), .counter_pin_a_out(a_out), .counter_pin_a_oe(a_oe),
    .counter_pin_b_in(pin_b), .counter_pin_b_out(b_out), .counter_pin_b_oe(b_oe),
    .sub_osc_input(sub_clk)
  );
  qrt_pin_src i_qrt_pin_src (.pclk(pclk), .pin_a(src_a), .pin_b(src_b), .sub_clk(sub_clk));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input apb_addr_t a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input apb_addr_t a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  // Notes the expected error flag and byte; the monitor compares them.
  task automatic rd(input apb_addr_t a, input logic [8:0] e);
    rq.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && rq.size() > 0) begin
      chk("read", {rq[0][8], 24'h0, rq[0][7:0]}, {pslverr, prdata});
      void'(rq.pop_front());
    end
  end

  task automatic wait_lvl(input int sel, input logic lv, output int t);
    int k;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (((sel == 0) ? irq : a_out) !== lv && k < 20000);
    t = cyc;
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #500000;
    error_cnt++;
    end_sim();
  end

  initial begin
    seed = 90197;
    cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`QRT_OFF_TMR1, 9'h0FF);
    rd(`QRT_OFF_MODE, 9'h000);
    rd(`QRT_OFF_STAT, 9'h000);
    rd(`QRT_OFF_CLR, 9'h000);
    rd(8'h30, 9'h100);
    rd(8'h05, 9'h100);
    $display("reset test done");
    n = ($random(seed) & 3) + 2;
    wr(`QRT_OFF_CLR, 8'h0F);
    wr(`QRT_OFF_IEN, 8'h04);
    wr(`QRT_OFF_PRE12, 8'h01);
    wr(`QRT_OFF_TMR2, 8'hFF);
    wr(`QRT_OFF_TMR1, n[7:0]);
    wait_lvl(0, 1'b1, t0);
    wr(`QRT_OFF_CLR, 8'h04);
    @(negedge pclk);
    chk("irq_clear", 33'h0, {32'h0, irq});
    wait_lvl(0, 1'b1, t1);
    chk("irq_period", (n + 1) * 32, t1 - t0);
    wr(`QRT_OFF_IEN, 8'h00);
    @(negedge pclk);
    chk("irq_mask", 33'h0, {32'h0, irq});
    rd(`QRT_OFF_STAT, 9'h004);
    $display("timer 1 test done");
    wr(`QRT_OFF_MODE, 8'h05);
    @(negedge pclk);
    chk("pulse_low", 33'h2, {31'h0, a_oe, a_out});
    wr(`QRT_OFF_MODE, 8'h00);
    wr(`QRT_OFF_PREX, 8'h00);
    wr(`QRT_OFF_TMRX, n[7:0]);
    wr(`QRT_OFF_MODE, 8'h01);
    @(negedge pclk);
    chk("pulse_high", 33'h3, {31'h0, a_oe, a_out});
    wait_lvl(1, 1'b0, t0);
    wait_lvl(1, 1'b1, t1);
    chk("pulse_half", (n + 1) * 16, t1 - t0);
    $display("pulse test done");
    v = 8'($random(seed)) | 8'h40;
    wr(`QRT_OFF_MODE, 8'h08);
    wr(`QRT_OFF_TMRX, v);
    repeat (100) @(posedge pclk);
    rd(`QRT_OFF_TMRX, {1'b0, v});
    wr(`QRT_OFF_IEN, 8'h01);
    rd(`QRT_OFF_IEN, 9'h001);
    for (int k = 0; k < 2; k++) begin
      i_qrt_pin_src.set_a(k[0]);
      wr(`QRT_OFF_MODE, k ? 8'h07 : 8'h03);
      wr(`QRT_OFF_TMRX, 8'h00);
      wr(`QRT_OFF_CLR, 8'h01);
      repeat (64) @(negedge pclk);
      chk("width_hold", 33'h0, {32'h0, irq});
    end
    wr(`QRT_OFF_MODE, 8'h03);
    repeat (40) @(negedge pclk);
    chk("width_count", 33'h1, {32'h0, irq});
    $display("stop and width test done");
    wr(`QRT_OFF_PREY, 8'h00);
    for (int e = 0; e < 2; e++) begin
      wr(`QRT_OFF_MODE, e ? 8'h60 : 8'h20);
      wr(`QRT_OFF_TMRY, 8'h06);
      n = ($random(seed) & 3) + 1;
      i_qrt_pin_src.burst(1, n);
      rd(`QRT_OFF_TMRY, 9'(6 - n));
    end
    $display("event test done");
    wr(`QRT_OFF_PORT_CONTROL_TWO, 8'h20);
    rd(`QRT_OFF_PORT_CONTROL_TWO, 9'h020);
    wr(`QRT_OFF_MODE, 8'h00);
    wr(`QRT_OFF_TMRY, 8'h06);
    i_qrt_pin_src.burst(2, n);
    repeat (50) @(posedge pclk);
    rd(`QRT_OFF_TMRY, 9'(6 - n));
    $display("sub source test done");
    repeat (4) @(posedge pclk);
    end_sim();
  end
endmodule
